/* pwm_duty_update_override.sv */
// PWM generator output stage with duty update and override control
//
// Local design decisions: register access over AXI4-Lite and the address map.
`timescale 1ns/1ns
module pwm_duty_update_override (
  // Clock and reset
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  // AXI4-Lite write address
  input  wire logic                      awvalid,
  output wire logic                      awready,
  input  wire logic [pwm_pkg::ADDR_W-1:0] awaddr,
  input  wire logic [2:0]                awprot,
  // AXI4-Lite write data
  input  wire logic                      wvalid,
  output wire logic                      wready,
  input  wire logic [31:0]               wdata,
  input  wire logic [3:0]                wstrb,
  // AXI4-Lite write response
  output wire logic                      bvalid,
  input  wire logic                      bready,
  output wire logic [1:0]                bresp,
  // AXI4-Lite read address
  input  wire logic                      arvalid,
  output wire logic                      arready,
  input  wire logic [pwm_pkg::ADDR_W-1:0] araddr,
  input  wire logic [2:0]                arprot,
  // AXI4-Lite read data
  output wire logic                      rvalid,
  input  wire logic                      rready,
  output wire logic [31:0]               rdata,
  output wire logic [1:0]                rresp,
  // PWM pins
  output wire logic                      pwm_high,
  output wire logic                      pwm_low
);
  import pwm_pkg::*;

  // ----------------------------------------------------------------
  // Register and state storage
  // ----------------------------------------------------------------
  logic [15:0]       time_base_control_reg;
  logic [15:0]       generator_control_reg;
  logic [15:0]       output_control_reg;
  logic [15:0]       local_duty_reg;
  logic [15:0]       master_duty_reg;
  logic [15:0]       period_reg;
  logic [15:0]       dead_time_reg;
  logic              aw_held;
  logic [ADDR_W-1:0] aw_addr_q;
  logic              w_held;
  logic [31:0]       w_data_q;
  logic [3:0]        w_strb_q;
  logic              bvalid_q;
  logic [1:0]        bresp_q;
  logic              rvalid_q;
  logic [31:0]       rdata_q;
  logic [1:0]        rresp_q;
  logic [7:0]        div_cnt;
  logic [15:0]       count;
  logic [15:0]       active_duty;
  logic              raw;
  logic              phase;
  logic              ovr_high_en;
  logic              ovr_low_en;
  logic              ovr_level_hi;
  logic              ovr_level_lo;

  // ----------------------------------------------------------------
  // Decoded controls
  // ----------------------------------------------------------------
  logic              run;
  logic              immediate;
  logic [1:0]        mode;
  logic [15:0]       selected_duty;
  logic [7:0]        div_limit;
  logic              tick;
  logic              boundary;
  logic              do_write;
  logic              wr_mapped;
  logic              rd_mapped;
  logic [31:0]       rd_value;

  pwm_stage_if stage_bus ();

  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    case (a)
      ADDR_TIME_BASE, ADDR_GEN_CTRL, ADDR_OUT_CTRL, ADDR_LOCAL_DUTY,
      ADDR_MASTER_DUTY, ADDR_PERIOD, ADDR_DEAD_TIME, ADDR_STATUS,
      ADDR_ACTIVE_DUTY: is_mapped = 1'b1;
      default:          is_mapped = 1'b0;
    endcase
  endfunction : is_mapped

  always_comb begin
    run       = time_base_control_reg[TB_ENABLE_BIT];
    immediate = generator_control_reg[GC_IMMEDIATE_BIT];
    mode      = output_control_reg[OC_MODE_LSB +: 2];
    selected_duty = generator_control_reg[GC_DUTY_SRC_BIT] ?
                    master_duty_reg : local_duty_reg;
    div_limit = 8'((8'h01 << time_base_control_reg[TB_PRESCALE_LSB +:
                TB_PRESCALE_W]) - 8'h01);
    tick      = run && (div_cnt >= div_limit);
    boundary  = tick && (count >= period_reg);
    do_write  = aw_held && w_held && !bvalid_q;
    wr_mapped = is_mapped(aw_addr_q);
    rd_mapped = is_mapped(araddr);
  end

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  // Address and data are each held until the other arrives, so the
  // master may offer them in either order.
  assign awready = !aw_held;
  assign wready  = !w_held;
  assign bvalid  = bvalid_q;
  assign bresp   = bresp_q;
  assign arready = !rvalid_q;
  assign rvalid  = rvalid_q;
  assign rdata   = rdata_q;
  assign rresp   = rresp_q;

  always_comb begin
    case (araddr)
      ADDR_TIME_BASE:   rd_value = {16'h0000, time_base_control_reg};
      ADDR_GEN_CTRL:    rd_value = {16'h0000, generator_control_reg};
      ADDR_OUT_CTRL:    rd_value = {16'h0000, output_control_reg};
      ADDR_LOCAL_DUTY:  rd_value = {16'h0000, local_duty_reg};
      ADDR_MASTER_DUTY: rd_value = {16'h0000, master_duty_reg};
      ADDR_PERIOD:      rd_value = {16'h0000, period_reg};
      ADDR_DEAD_TIME:   rd_value = {16'h0000, dead_time_reg};
      ADDR_STATUS:      rd_value = {13'h0000, phase, stage_bus.out_l,
                                    stage_bus.out_h, count};
      ADDR_ACTIVE_DUTY: rd_value = {16'h0000, active_duty};
      default:          rd_value = 32'h0000_0000;
    endcase
  end

  logic              next_aw_held;
  logic [ADDR_W-1:0] next_aw_addr_q;
  logic              next_w_held;
  logic [31:0]       next_w_data_q;
  logic [3:0]        next_w_strb_q;
  logic              next_bvalid_q;
  logic [1:0]        next_bresp_q;
  logic              next_rvalid_q;
  logic [31:0]       next_rdata_q;
  logic [1:0]        next_rresp_q;

  always_comb begin
    next_aw_held   = aw_held;
    next_aw_addr_q = aw_addr_q;
    next_w_held    = w_held;
    next_w_data_q  = w_data_q;
    next_w_strb_q  = w_strb_q;
    next_bvalid_q  = bvalid_q;
    next_bresp_q   = bresp_q;
    next_rvalid_q  = rvalid_q;
    next_rdata_q   = rdata_q;
    next_rresp_q   = rresp_q;
    if (awvalid && !aw_held) begin
      next_aw_held   = 1'b1;
      next_aw_addr_q = awaddr;
    end
    if (wvalid && !w_held) begin
      next_w_held   = 1'b1;
      next_w_data_q = wdata;
      next_w_strb_q = wstrb;
    end
    if (do_write) begin
      next_aw_held  = 1'b0;
      next_w_held   = 1'b0;
      next_bvalid_q = 1'b1;
      next_bresp_q  = wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid_q && bready) begin
      next_bvalid_q = 1'b0;
    end
    if (arvalid && !rvalid_q) begin
      next_rvalid_q = 1'b1;
      next_rdata_q  = rd_value;
      next_rresp_q  = rd_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_q && rready) begin
      next_rvalid_q = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held   <= 1'b0;
      aw_addr_q <= '0;
      w_held    <= 1'b0;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= RESP_OKAY;
    end else begin
      aw_held   <= next_aw_held;
      aw_addr_q <= next_aw_addr_q;
      w_held    <= next_w_held;
      w_data_q  <= next_w_data_q;
      w_strb_q  <= next_w_strb_q;
      bvalid_q  <= next_bvalid_q;
      bresp_q   <= next_bresp_q;
      rvalid_q  <= next_rvalid_q;
      rdata_q   <= next_rdata_q;
      rresp_q   <= next_rresp_q;
    end
  end

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  // Immediate update may change while running; the resulting waveform
  // is only clean if software keeps to setup before enable.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      time_base_control_reg <= CTRL_RESET;
      generator_control_reg <= CTRL_RESET;
      output_control_reg    <= CTRL_RESET;
      local_duty_reg        <= DUTY_RESET;
      master_duty_reg       <= DUTY_RESET;
      period_reg            <= PERIOD_RESET;
      dead_time_reg         <= DEAD_RESET;
    end else if (do_write) begin
      case (aw_addr_q)
        ADDR_TIME_BASE: time_base_control_reg <= merge_bytes(
          time_base_control_reg, w_data_q, w_strb_q, TB_WMASK);
        ADDR_GEN_CTRL: generator_control_reg <= merge_bytes(
          generator_control_reg, w_data_q, w_strb_q, GC_WMASK);
        ADDR_OUT_CTRL: output_control_reg <= merge_bytes(
          output_control_reg, w_data_q, w_strb_q, OC_WMASK);
        ADDR_LOCAL_DUTY: local_duty_reg <= merge_bytes(
          local_duty_reg, w_data_q, w_strb_q, 16'hFFFF);
        ADDR_MASTER_DUTY: master_duty_reg <= merge_bytes(
          master_duty_reg, w_data_q, w_strb_q, 16'hFFFF);
        ADDR_PERIOD: period_reg <= merge_bytes(
          period_reg, w_data_q, w_strb_q, 16'hFFFF);
        ADDR_DEAD_TIME: dead_time_reg <= merge_bytes(
          dead_time_reg, w_data_q, w_strb_q, 16'hFFFF);
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Time base and duty compare
  // ----------------------------------------------------------------
  logic [7:0]  next_div_cnt;
  logic [15:0] next_count;
  logic [15:0] next_active_duty;
  logic        next_raw;
  logic        next_phase;
  logic [15:0] duty_now;

  always_comb begin
    next_div_cnt     = div_cnt;
    next_count       = count;
    next_active_duty = active_duty;
    next_raw         = raw;
    next_phase       = phase;
    duty_now         = active_duty;
    if (immediate) begin
      duty_now = selected_duty;
    end else if (boundary) begin
      duty_now = selected_duty;
    end
    if (!run) begin
      next_div_cnt     = 8'h00;
      next_count       = 16'h0000;
      next_active_duty = selected_duty;
      next_raw         = 1'b0;
      next_phase       = 1'b0;
    end else if (tick) begin
      next_div_cnt     = 8'h00;
      next_count       = boundary ? 16'h0000 : count + 16'h0001;
      next_active_duty = duty_now;
      // New duty and new count are compared together, so a change to
      // zero never leaves a one-tick pulse at the boundary.
      next_raw         = (next_count < duty_now);
      next_phase       = boundary ? !phase : phase;
    end else begin
      next_div_cnt     = div_cnt + 8'h01;
      if (immediate) begin
        next_active_duty = selected_duty;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_cnt     <= 8'h00;
      count       <= 16'h0000;
      active_duty <= DUTY_RESET;
      raw         <= 1'b0;
      phase       <= 1'b0;
    end else begin
      div_cnt     <= next_div_cnt;
      count       <= next_count;
      active_duty <= next_active_duty;
      raw         <= next_raw;
      phase       <= next_phase;
    end
  end

  // ----------------------------------------------------------------
  // Override capture
  // ----------------------------------------------------------------
  logic next_ovr_high_en;
  logic next_ovr_low_en;
  logic next_ovr_level_hi;
  logic next_ovr_level_lo;

  always_comb begin
    next_ovr_high_en  = ovr_high_en;
    next_ovr_low_en   = ovr_low_en;
    next_ovr_level_hi = ovr_level_hi;
    next_ovr_level_lo = ovr_level_lo;
    if (!output_control_reg[OC_SYNC_BIT] || !run || boundary) begin
      next_ovr_high_en  = output_control_reg[OC_HIGH_OVR_BIT];
      next_ovr_low_en   = output_control_reg[OC_LOW_OVR_BIT];
      next_ovr_level_hi = output_control_reg[OC_LEVEL_HI_BIT];
      next_ovr_level_lo = output_control_reg[OC_LEVEL_LO_BIT];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ovr_high_en  <= 1'b0;
      ovr_low_en   <= 1'b0;
      ovr_level_hi <= 1'b0;
      ovr_level_lo <= 1'b0;
    end else begin
      ovr_high_en  <= next_ovr_high_en;
      ovr_low_en   <= next_ovr_low_en;
      ovr_level_hi <= next_ovr_level_hi;
      ovr_level_lo <= next_ovr_level_lo;
    end
  end

  // ----------------------------------------------------------------
  // Output mode and override mux
  // ----------------------------------------------------------------
  logic gen_h;
  logic gen_l;

  always_comb begin
    case (mode)
      MODE_REDUNDANT: begin
        gen_h = raw;
        gen_l = raw;
      end
      MODE_PUSH_PULL: begin
        gen_h = raw && !phase;
        gen_l = raw && phase;
      end
      MODE_INDEPENDENT: begin
        gen_h = raw;
        gen_l = raw;
      end
      default: begin
        gen_h = raw;
        gen_l = run && !raw;
      end
    endcase
    stage_bus.tick     = tick;
    stage_bus.dt_en    = (mode == MODE_COMPLEMENTARY);
    stage_bus.dt_ticks = dead_time_reg;
    // A disabled override falls straight back to the duty waveform
    stage_bus.want_h = ovr_high_en ? ovr_level_hi : gen_h;
    stage_bus.want_l = ovr_low_en ? ovr_level_lo : gen_l;
  end

  pwm_dead_time u_dead_time (
    .aclk    (aclk),
    .aresetn (aresetn),
    .st      (stage_bus)
  );

  assign pwm_high = stage_bus.out_h;
  assign pwm_low  = stage_bus.out_l;

endmodule : pwm_duty_update_override

/* pwm_pkg.sv */
// Constants, register map and helpers shared by the PWM output stage
package pwm_pkg;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam int          ADDR_W           = 8;
  localparam logic [7:0]  ADDR_TIME_BASE   = 8'h00;
  localparam logic [7:0]  ADDR_GEN_CTRL    = 8'h04;
  localparam logic [7:0]  ADDR_OUT_CTRL    = 8'h08;
  localparam logic [7:0]  ADDR_LOCAL_DUTY  = 8'h0C;
  localparam logic [7:0]  ADDR_MASTER_DUTY = 8'h10;
  localparam logic [7:0]  ADDR_PERIOD      = 8'h14;
  localparam logic [7:0]  ADDR_DEAD_TIME   = 8'h18;
  localparam logic [7:0]  ADDR_STATUS      = 8'h1C;
  localparam logic [7:0]  ADDR_ACTIVE_DUTY = 8'h20;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int TB_ENABLE_BIT    = 15;
  localparam int TB_PRESCALE_LSB  = 0;
  localparam int TB_PRESCALE_W    = 3;
  localparam int GC_IMMEDIATE_BIT = 0;
  localparam int GC_DUTY_SRC_BIT  = 8;
  localparam int OC_MODE_LSB      = 10;
  localparam int OC_HIGH_OVR_BIT  = 9;
  localparam int OC_LOW_OVR_BIT   = 8;
  localparam int OC_LEVEL_HI_BIT  = 7;
  localparam int OC_LEVEL_LO_BIT  = 6;
  localparam int OC_SYNC_BIT      = 0;

  // Writable bits; the rest read as zero
  localparam logic [15:0] TB_WMASK = 16'h8007;
  localparam logic [15:0] GC_WMASK = 16'h0101;
  localparam logic [15:0] OC_WMASK = 16'h0FC1;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] PERIOD_RESET = 16'h00FF;
  localparam logic [15:0] DUTY_RESET   = 16'h0000;
  localparam logic [15:0] DEAD_RESET   = 16'h0000;
  localparam logic [15:0] CTRL_RESET   = 16'h0000;

  // ----------------------------------------------------------------
  // Output modes and bus answers
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_COMPLEMENTARY = 2'h0;
  localparam logic [1:0] MODE_PUSH_PULL     = 2'h1;
  localparam logic [1:0] MODE_REDUNDANT     = 2'h2;
  localparam logic [1:0] MODE_INDEPENDENT   = 2'h3;
  localparam logic [1:0] RESP_OKAY          = 2'h0;
  localparam logic [1:0] RESP_SLVERR        = 2'h2;

  // Byte-lane merge of a 16-bit register; upper lanes have no storage
  function automatic logic [15:0] merge_bytes(input logic [15:0] old,
                                              input logic [31:0] data,
                                              input logic [3:0]  strb,
                                              input logic [15:0] mask);
    logic [15:0] v;
    v = old;
    if (strb[0]) begin
      v[7:0] = data[7:0];
    end
    if (strb[1]) begin
      v[15:8] = data[15:8];
    end
    return v & mask;
  endfunction : merge_bytes

endpackage : pwm_pkg

/* pwm_stage_if.sv */
// Signals between the waveform generator and the dead-time output stage
`timescale 1ns/1ns
interface pwm_stage_if;
  logic        tick;
  logic        dt_en;
  logic [15:0] dt_ticks;
  logic        want_h;
  logic        want_l;
  logic        out_h;
  logic        out_l;

  modport gen   (output tick, dt_en, dt_ticks, want_h, want_l,
                 input  out_h, out_l);
  modport stage (input  tick, dt_en, dt_ticks, want_h, want_l,
                 output out_h, out_l);
endinterface : pwm_stage_if

/* pwm_dead_time.sv */
// Output stage: registers the pin levels and inserts dead time
`timescale 1ns/1ns
module pwm_dead_time (
  // Clock and reset
  input  wire logic   aclk,
  input  wire logic   aresetn,
  // Generator side
  pwm_stage_if.stage  st
);
  import pwm_pkg::*;

  logic        out_h;
  logic        out_l;
  logic [15:0] gap;
  logic        next_out_h;
  logic        next_out_l;
  logic [15:0] next_gap;
  logic        gap_ok;

  // ----------------------------------------------------------------
  // Dead-time decision
  // ----------------------------------------------------------------
  // In complementary mode a side may rise only after both have been low for the dead time,
  // whatever caused the change, overrides released included.
  always_comb begin
    gap_ok     = (gap >= st.dt_ticks);
    next_out_h = st.want_h &&
                 (out_h || !st.dt_en || (!out_l && gap_ok));
    next_out_l = st.want_l && (out_l || !st.dt_en ||
                 (!out_h && !next_out_h && gap_ok));
    next_gap   = gap;
    if (out_h || out_l) begin
      next_gap = 16'h0000;
    end else if (st.tick && gap != 16'hFFFF) begin
      next_gap = gap + 16'h0001;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_h <= 1'b0;
      out_l <= 1'b0;
      gap   <= 16'h0000;
    end else begin
      out_h <= next_out_h;
      out_l <= next_out_l;
      gap   <= next_gap;
    end
  end

  assign st.out_h = out_h;
  assign st.out_l = out_l;

endmodule : pwm_dead_time

/* pwm_duty_update_override_monitor.sv */
// Checker of bus answers and pin levels of the PWM output stage
`timescale 1ns/1ns
module pwm_duty_update_override_monitor (
  // Clock and reset
  input wire logic                       aclk,
  input wire logic                       aresetn,
  // Bus
  input wire logic                       awvalid,
  input wire logic                       awready,
  input wire logic [pwm_pkg::ADDR_W-1:0] awaddr,
  input wire logic                       wvalid,
  input wire logic                       wready,
  input wire logic [31:0]                wdata,
  input wire logic                       bvalid,
  input wire logic                       bready,
  input wire logic [1:0]                 bresp,
  input wire logic                       arvalid,
  input wire logic                       arready,
  input wire logic [pwm_pkg::ADDR_W-1:0] araddr,
  input wire logic                       rvalid,
  input wire logic [1:0]                 rresp,
  // Pins
  input wire logic                       pwm_high,
  input wire logic                       pwm_low
);
  import pwm_pkg::*;
  // ----------------------------------------------------------------
  // Shadow of committed writes; lags the design, so checks stay safe
  // ----------------------------------------------------------------
  logic [7:0]  aw_q;
  logic [7:0]  ar_q;
  logic [15:0] w_q;
  logic [1:0]  mode;
  logic [1:0]  ovr;
  logic        en;
  logic        wr_done;
  assign wr_done = bvalid && bready && bresp == RESP_OKAY;
  function automatic logic unmapped(input logic [7:0] a);
    return a > ADDR_ACTIVE_DUTY || a[1:0] != 2'h0;
  endfunction : unmapped
  always_ff @(posedge aclk) begin
    if (awvalid && awready) aw_q <= awaddr;
    if (arvalid && arready) ar_q <= araddr;
    if (wvalid && wready) w_q <= wdata[15:0];
    if (!aresetn) begin
      mode <= MODE_COMPLEMENTARY;
      ovr  <= 2'h0;
      en   <= 1'b0;
    end else if (wr_done && aw_q == ADDR_OUT_CTRL) begin
      mode <= w_q[11:10];
      ovr  <= w_q[9:8];
    end else if (wr_done && aw_q == ADDR_TIME_BASE) begin
      en <= w_q[15];
    end
  end
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence wr_take;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence wr_answer;
    !awready && !bvalid ##1 bvalid;
  endsequence
  sequence ovr_cmd;
    wr_done && aw_q == ADDR_OUT_CTRL && w_q[9:6] == 4'hC && !w_q[0];
  endsequence
  write_turn_a: assert property (wr_take |=> wr_answer)
    else $error("write answer out of step");
  write_resp_a: assert property (bvalid |->
    bresp == (unmapped(aw_q) ? RESP_SLVERR : RESP_OKAY))
    else $error("write response code wrong");
  read_turn_a: assert property (arvalid && arready |=>
    rvalid && rresp == (unmapped(ar_q) ? RESP_SLVERR : RESP_OKAY))
    else $error("read answer wrong");
  idle_low_a: assert property (!en && $past(en, 4) == 1'b0 && ovr == 2'h0
    |-> !pwm_high && !pwm_low) else $error("pins active while disabled");
  ovr_low_a: assert property (
    ovr_cmd |-> ##[0:3] (!pwm_high && !pwm_low)[*4])
    else $error("override did not force low");
  dead_excl_a: assert property (
    mode == MODE_COMPLEMENTARY && ovr == 2'h0 |-> !(pwm_high && pwm_low))
    else $error("complementary pins overlap");
  redundant_a: assert property (
    mode == MODE_REDUNDANT && $past(mode, 4) == MODE_REDUNDANT
    |-> pwm_high == pwm_low) else $error("redundant pins differ");
  push_pull_a: assert property (
    mode == MODE_PUSH_PULL && $past(mode, 4) == MODE_PUSH_PULL
    |-> !(pwm_high && pwm_low)) else $error("push-pull pins overlap");
endmodule : pwm_duty_update_override_monitor

bind pwm_duty_update_override pwm_duty_update_override_monitor mon_u (
  .aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata,
  .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rresp,
  .pwm_high, .pwm_low);

/* tb.sv */
// Self-checking bench for the PWM output stage
`timescale 1ns/1ns
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin \
  num_errors++; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, \
  got, exp); end end
module tb;
  import pwm_pkg::*;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
  logic arvalid = 0, rready = 0, awready, wready, bvalid, arready, rvalid;
  logic pwm_high, pwm_low;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, h, l;
  logic [3:0]  wstrb = 4'hF;
  logic [2:0]  awprot = 3'h0, arprot = 3'h0;
  logic [1:0]  bresp, rresp, m;
  int num_errors = 0, comparisons = 0, cyc = 0;
  always #10 aclk = ~aclk;
  pwm_duty_update_override dut_u (.aclk(aclk), .aresetn(aresetn),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(awprot),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
    .arready(arready), .araddr(araddr), .arprot(arprot), .rvalid(rvalid),
    .rready(rready), .rdata(rdata), .rresp(rresp), .pwm_high(pwm_high),
    .pwm_low(pwm_low));
  // ----------------------------------------------------------------
  // Bus and measuring tasks
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    bit aw, wd;
    aw = 0;
    wd = 0;
    @(posedge aclk);
    {awvalid, wvalid, bready} <= 3'b111;
    awaddr <= a;
    wdata <= d;
    while (!(aw && wd)) begin
      @(posedge aclk);
      if (!aw && awready) begin
        awvalid <= 1'b0;
        aw = 1;
      end
      if (!wd && wready) begin
        wvalid <= 1'b0;
        wd = 1;
      end
    end
    do @(posedge aclk); while (!bvalid);
    bready <= 1'b0;
    `CHK(bresp, er)
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                    input logic [1:0] er);
    @(posedge aclk);
    {arvalid, rready} <= 2'b11;
    araddr <= a;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    rready <= 1'b0;
    `CHK(rdata, ed)
    `CHK(rresp, er)
  endtask : rd
  // Counts cover whole periods of 8, so start phase does not matter
  task automatic cnt(input int n);
    h = 0;
    l = 0;
    repeat (n) begin
      @(posedge aclk);
      h += pwm_high;
      l += pwm_low;
    end
  endtask : cnt
  task automatic meas;
    repeat (16) @(posedge aclk);
    cnt(64);
  endtask : meas
  task automatic done(input string s);
    $display("test %s done", s);
  endtask : done
  task automatic finish_test;
    $display("comparisons=%0d num_errors=%0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : finish_test
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 6000) begin
      num_errors++;
      finish_test();
    end
  end
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rd(ADDR_PERIOD, {16'h0, PERIOD_RESET}, RESP_OKAY);
    wr(ADDR_GEN_CTRL, 32'hFFFFFFFF, RESP_OKAY);
    rd(ADDR_GEN_CTRL, {16'h0, GC_WMASK}, RESP_OKAY);
    wr(ADDR_ACTIVE_DUTY, 32'h55, RESP_OKAY);
    wr(8'h24, 32'h1, RESP_SLVERR);
    rd(8'h24, 32'h0, RESP_SLVERR);
    done("registers");
    wr(ADDR_GEN_CTRL, 32'h0, RESP_OKAY);
    wr(ADDR_LOCAL_DUTY, 32'h3, RESP_OKAY);
    rd(ADDR_ACTIVE_DUTY, 32'h3, RESP_OKAY);
    wr(ADDR_MASTER_DUTY, 32'h5, RESP_OKAY);
    wr(ADDR_PERIOD, 32'h7, RESP_OKAY);
    wr(ADDR_GEN_CTRL, 32'h100, RESP_OKAY);
    wr(ADDR_TIME_BASE, 32'h8000, RESP_OKAY);
    meas();
    // A rising side waits one clock for the other side to fall, so
    // even with no dead time each pulse is one clock short
    `CHK(h, 32'd32)
    rd(ADDR_ACTIVE_DUTY, 32'h5, RESP_OKAY);
    wr(ADDR_GEN_CTRL, 32'h0, RESP_OKAY);
    meas();
    `CHK(h, 32'd16)
    rd(ADDR_ACTIVE_DUTY, 32'h3, RESP_OKAY);
    done("duty source");
    wr(ADDR_TIME_BASE, 32'h0, RESP_OKAY);
    // Slowest ticks: the next boundary is some 1024 clocks away, and
    // each duty write lands just after a period starts
    wr(ADDR_TIME_BASE, 32'h8007, RESP_OKAY);
    wr(ADDR_LOCAL_DUTY, 32'h6, RESP_OKAY);
    rd(ADDR_ACTIVE_DUTY, 32'h3, RESP_OKAY);
    wr(ADDR_TIME_BASE, 32'h0, RESP_OKAY);
    wr(ADDR_GEN_CTRL, 32'h1, RESP_OKAY);
    wr(ADDR_TIME_BASE, 32'h8007, RESP_OKAY);
    wr(ADDR_LOCAL_DUTY, 32'h2, RESP_OKAY);
    rd(ADDR_ACTIVE_DUTY, 32'h2, RESP_OKAY);
    wr(ADDR_TIME_BASE, 32'h0, RESP_OKAY);
    wr(ADDR_GEN_CTRL, 32'h0, RESP_OKAY);
    wr(ADDR_LOCAL_DUTY, 32'h3, RESP_OKAY);
    wr(ADDR_TIME_BASE, 32'h8000, RESP_OKAY);
    done("immediate update");
    // A period of 8 clocks keeps every override command near a boundary
    wr(ADDR_OUT_CTRL, 32'h300, RESP_OKAY);
    meas();
    `CHK(h + l, 32'd0)
    wr(ADDR_DEAD_TIME, 32'h1, RESP_OKAY);
    wr(ADDR_OUT_CTRL, 32'h0, RESP_OKAY);
    meas();
    `CHK(h, 32'd8)
    `CHK(l, 32'd24)
    wr(ADDR_OUT_CTRL, 32'h301, RESP_OKAY);
    meas();
    `CHK(h + l, 32'd0)
    done("override");
    for (int i = 0; i < 3; i++) begin
      m = (i == 0) ? MODE_REDUNDANT : (i == 1) ? MODE_PUSH_PULL :
          MODE_INDEPENDENT;
      wr(ADDR_LOCAL_DUTY, 32'h3, RESP_OKAY);
      wr(ADDR_OUT_CTRL, {20'h0, m, 10'h0}, RESP_OKAY);
      meas();
      `CHK(h, (i == 1) ? 32'd12 : 32'd24)
      `CHK(l, (i == 1) ? 32'd12 : 32'd24)
      // Write just after a pulse starts, so it lands before the boundary
      do @(posedge aclk); while (!(pwm_high || pwm_low));
      wr(ADDR_LOCAL_DUTY, 32'h0, RESP_OKAY);
      cnt(64);
      `CHK(h + l, 32'd0)
    end
    done("modes");
    finish_test();
  end
endmodule : tb
